// ==== rtl/pci_dma_master_cmd_select.sv ====
// Module: DMA master command selection, reset tri-state and interrupt pins
//
// Functional notes
// - Reads of one or two phases: memory read
// - Longer reads chosen by 2-bit select field
// - Read codes 6, C, E; reads only
// - Writes use code 7 or F
// - Global reset holds all drivers off
// - Interrupt A/B outputs, master and target capable
`timescale 1ns/1ps
module pci_dma_master_cmd_select #(
	parameter logic [3:0] SEL1_CMD = dma_cmd_pkg::SEL1_CMD_DEFAULT,
	parameter logic [3:0] SEL2_CMD = dma_cmd_pkg::SEL2_CMD_DEFAULT,
	parameter logic [3:0] SEL3_CMD = dma_cmd_pkg::SEL3_CMD_DEFAULT
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic global_reset_n,
	input wire logic [15:0] misc_config,
	input wire logic req_valid,
	input wire dma_cmd_pkg::dma_req_t req,
	input wire logic addr_phase,
	input wire logic target_active,
	input wire logic irq_a,
	input wire logic irq_b,
	output logic cmd_valid,
	output dma_cmd_pkg::dma_cmd_t cmd_out,
	output logic [3:0] cbe_out,
	output logic cbe_oe,
	output logic inta_n_out,
	output logic inta_n_oe,
	output logic intb_n_out,
	output logic intb_n_oe
);
	// ****************************************************
	// Pin synchronisers
	// ****************************************************
	logic global_reset_n_meta_r;
	logic global_reset_n_sync_r;
	logic [1:0] irq_meta_r;
	logic [1:0] irq_sync_r;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			global_reset_n_meta_r <= 1'b0;
			global_reset_n_sync_r <= 1'b0;
		end else begin
			global_reset_n_meta_r <= global_reset_n;
			global_reset_n_sync_r <= global_reset_n_meta_r;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_meta_r <= 2'h0;
			irq_sync_r <= 2'h0;
		end else begin
			irq_meta_r <= {irq_b, irq_a};
			irq_sync_r <= irq_meta_r;
		end
	end

	// Global reset active if either the pin or the local reset says so
	logic drive_ok;
	assign drive_ok = global_reset_n_sync_r;

	// ****************************************************
	// Command choice
	// ****************************************************
	logic [1:0] sel_r;
	logic [3:0] cmd_nxt;

	// Field only sampled outside global reset; it returns to zero there
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sel_r <= dma_cmd_pkg::SEL_RESET;
		end else if (!drive_ok) begin
			sel_r <= dma_cmd_pkg::SEL_RESET;
		end else begin
			sel_r <= misc_config[dma_cmd_pkg::SEL_MSB:dma_cmd_pkg::SEL_LSB];
		end
	end

	read_cmd_map #(
		.SEL1_CMD(SEL1_CMD),
		.SEL2_CMD(SEL2_CMD),
		.SEL3_CMD(SEL3_CMD)
	) u_map (
		.req(req),
		.long_read_cmd_select(sel_r),
		.cmd(cmd_nxt)
	);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cmd_valid <= 1'b0;
			cmd_out <= '0;
		end else if (!drive_ok) begin
			cmd_valid <= 1'b0;
			cmd_out <= '0;
		end else begin
			cmd_valid <= req_valid;
			if (req_valid) begin
				cmd_out.cmd <= cmd_nxt;
				cmd_out.is_write <= req.is_write;
				cmd_out.phases <= req.phases;
			end
		end
	end

	// ****************************************************
	// Command/byte-enable drivers
	// ****************************************************
	// drivers off in reset
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cbe_out <= 4'h0;
			cbe_oe <= 1'b0;
		end else if (!drive_ok) begin
			cbe_out <= 4'h0;
			cbe_oe <= 1'b0;
		end else begin
			cbe_oe <= addr_phase && req_valid && !target_active;
			cbe_out <= (addr_phase && req_valid && !target_active) ? cmd_nxt : 4'h0;
		end
	end

	// ****************************************************
	// Interrupt pins, open drain
	// ****************************************************
	// interrupt A and B
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			inta_n_out <= 1'b0;
			inta_n_oe <= 1'b0;
			intb_n_out <= 1'b0;
			intb_n_oe <= 1'b0;
		end else begin
			inta_n_out <= 1'b0;
			intb_n_out <= 1'b0;
			inta_n_oe <= drive_ok && irq_sync_r[0];
			intb_n_oe <= drive_ok && irq_sync_r[1];
		end
	end

	// Target cycles keep the master off the command lines, so both
	// roles can share the pins without contention.
endmodule

// ==== inc/dma_cmd_pkg.sv ====
// Package: command codes, select values, reset and timing constants
package dma_cmd_pkg;

	// ****************************************************
	// Bus command codes
	// ****************************************************
	localparam logic [3:0] CMD_MEM_READ = 4'h6;
	localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
	localparam logic [3:0] CMD_MEM_READ_MULT = 4'hC;
	localparam logic [3:0] CMD_MEM_READ_LINE = 4'hE;
	localparam logic [3:0] CMD_MEM_WRITE_INV = 4'hF;

	// ****************************************************
	// Configuration field layout
	// ****************************************************
	localparam int SEL_LSB = 8;
	localparam int SEL_MSB = 9;
	localparam logic [1:0] SEL_RESET = 2'h0;
	localparam logic [15:0] SHORT_READ_MAX_PHASES = 16'h0002;

	// Default mapping of select values 1..3 to long-read commands
	localparam logic [3:0] SEL1_CMD_DEFAULT = 4'hE;
	localparam logic [3:0] SEL2_CMD_DEFAULT = 4'hC;
	localparam logic [3:0] SEL3_CMD_DEFAULT = 4'hC;

	// ****************************************************
	// Reset timing expected from the system
	// ****************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int GLOBAL_RESET_N_MIN_US = 100;
	localparam int GLOBAL_RESET_N_MIN_CYCLES = (GLOBAL_RESET_N_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed {
		logic is_write;
		logic use_invalidate;
		logic [15:0] phases;
	} dma_req_t;

	typedef struct packed {
		logic [3:0] cmd;
		logic is_write;
		logic [15:0] phases;
	} dma_cmd_t;

endpackage

// ==== rtl/read_cmd_map.sv ====
// Module: maps a DMA request and select field to a bus command
`timescale 1ns/1ps
module read_cmd_map #(
	parameter logic [3:0] SEL1_CMD = dma_cmd_pkg::SEL1_CMD_DEFAULT,
	parameter logic [3:0] SEL2_CMD = dma_cmd_pkg::SEL2_CMD_DEFAULT,
	parameter logic [3:0] SEL3_CMD = dma_cmd_pkg::SEL3_CMD_DEFAULT
) (
	input wire dma_cmd_pkg::dma_req_t req,
	input wire logic [1:0] long_read_cmd_select,
	output logic [3:0] cmd
);
	always_comb begin
		cmd = dma_cmd_pkg::CMD_MEM_READ;
		if (req.is_write) begin
			cmd = req.use_invalidate ? dma_cmd_pkg::CMD_MEM_WRITE_INV
				: dma_cmd_pkg::CMD_MEM_WRITE;
		end else if (req.phases <= dma_cmd_pkg::SHORT_READ_MAX_PHASES) begin
			cmd = dma_cmd_pkg::CMD_MEM_READ;
		end else begin
			case (long_read_cmd_select)
				2'h0: cmd = dma_cmd_pkg::CMD_MEM_READ;
				2'h1: cmd = SEL1_CMD;
				2'h2: cmd = SEL2_CMD;
				2'h3: cmd = SEL3_CMD;
				default: cmd = dma_cmd_pkg::CMD_MEM_READ;
			endcase
		end
	end
endmodule

// ==== bench/pci_bus_partner.sv ====
// Partner: bus wire levels seen by host memory and arbiter
`timescale 1ns/1ps
module pci_bus_partner (
	input wire logic clock,
	input wire logic [3:0] cbe_out,
	input wire logic cbe_oe,
	input wire logic inta_n_oe,
	input wire logic intb_n_oe,
	output logic [3:0] cbe_bus,
	output logic inta_bus,
	output logic intb_bus
);
	logic [3:0] last_r = 4'h0;
	always_ff @(posedge clock) last_r <= cbe_bus;
	assign cbe_bus = cbe_oe ? cbe_out : ~last_r;
	assign inta_bus = !inta_n_oe;
	assign intb_bus = !intb_n_oe;
endmodule

// ==== bench/cmd_select_monitor.sv ====
// Checker: command choice, reset float and interrupt pin
`timescale 1ns/1ps
module cmd_select_monitor (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic global_reset_n,
	input wire logic [15:0] misc_config,
	input wire logic req_valid,
	input wire dma_cmd_pkg::dma_req_t req,
	input wire logic irq_a,
	input wire logic cmd_valid,
	input wire dma_cmd_pkg::dma_cmd_t cmd_out,
	input wire logic cbe_oe,
	input wire logic inta_n_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence taken;
		global_reset_n[*5] ##0 req_valid;
	endsequence
	a_short_read: assert property (
		taken ##0 (!req.is_write && req.phases <= 16'h0002) |=> cmd_out.cmd == 4'h6)
		else $error("bad short read");
	a_long_read: assert property (
		taken ##0 (!req.is_write && req.phases > 16'h0002 && $stable(misc_config))
		|=> cmd_out.cmd == ($past(misc_config[9:8]) == 2'h0 ? 4'h6
		: $past(misc_config[9:8]) == 2'h1 ? 4'hE : 4'hC)) else $error("bad long read");
	a_read_codes: assert property (
		cmd_valid && !cmd_out.is_write |-> cmd_out.cmd inside {4'h6, 4'hC, 4'hE})
		else $error("bad read code");
	a_write_codes: assert property (
		cmd_valid && cmd_out.is_write |-> cmd_out.cmd inside {4'h7, 4'hF})
		else $error("bad write code");
	a_float_reset: assert property (
		(!global_reset_n)[*3] |=> !cbe_oe && !inta_n_oe && !cmd_valid)
		else $error("driving in reset");
	a_int_a_on: assert property (
		(irq_a && global_reset_n)[*5] |-> inta_n_oe) else $error("interrupt not driven");
	a_valid_next: assert property (
		taken |=> cmd_valid && cmd_out.is_write == $past(req.is_write))
		else $error("bad answer");
endmodule
bind pci_dma_master_cmd_select cmd_select_monitor i_cmd_select_monitor (.*);

// ==== bench/pci_dma_master_cmd_select_tb_top.sv ====
// Testbench: random and corner DMA requests, reset float, interrupts
`timescale 1ns/1ps
module pci_dma_master_cmd_select_tb_top;
	logic clock = 0, reset_n = 0, global_reset_n = 0, req_valid = 0, addr_phase = 0;
	logic target_active = 0, irq_a = 1, irq_b = 1, cmd_valid, cbe_oe, inta_n_out;
	logic inta_n_oe, intb_n_out, intb_n_oe, inta_bus, intb_bus;
	logic [15:0] misc_config = 16'h0000;
	logic [3:0] cbe_out, cbe_bus;
	dma_cmd_pkg::dma_req_t req = '0;
	dma_cmd_pkg::dma_cmd_t cmd_out;
	int n_mismatch = 0, n_compared = 0, seed = 41606, i, s;
	initial forever #5 clock = ~clock;
	pci_dma_master_cmd_select i_pci_dma_master_cmd_select (.*);
	pci_bus_partner i_pci_bus_partner (.*);
	task automatic check(logic ok);
		n_compared++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("BAD %0t unexpected output", $time);
		end
	endtask
	task automatic test_done;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	function automatic logic [3:0] exp_read(logic [15:0] ph, logic [1:0] sel);
		return (ph <= 16'h0002 || sel == 2'h0) ? 4'h6 : (sel == 2'h1 ? 4'hE : 4'hC);
	endfunction
	task automatic send(logic w, logic inv, logic [15:0] ph);
		@(posedge clock);
		req_valid <= 1'b1;
		addr_phase <= 1'b1;
		req <= {w, inv, ph};
		@(posedge clock);
		#1;
		check(cmd_valid === 1'b1 && cmd_out.is_write === w && cmd_out.phases === ph);
		if (w) check(cmd_out.cmd inside {4'h7, 4'hF});
		else check(cmd_out.cmd === exp_read(ph, misc_config[9:8]));
		check(cbe_oe === 1'b1 && cbe_bus === cmd_out.cmd);
	endtask
	initial begin
		req_valid = 1'b1;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		repeat (dma_cmd_pkg::GLOBAL_RESET_N_MIN_CYCLES) @(posedge clock);
		#1;
		check(!cbe_oe && !cmd_valid && inta_bus && intb_bus);
		global_reset_n <= 1'b1;
		{req_valid, irq_a, irq_b} <= 3'h0;
		repeat (4) @(posedge clock);
		for (s = 0; s < 4; s++) begin
			req_valid <= 1'b0;
			misc_config <= 16'($random(seed)) & 16'hFCFF | 16'(s << 8);
			repeat (2) @(posedge clock);
			for (i = 0; i < 5; i++) send(1'b0, 1'b0, i < 4 ? 16'(i) : 16'hFFFF);
			for (i = 0; i < 30; i++) send(1'($random(seed)), 1'($random(seed)),
				i[0] ? 16'($random(seed)) : 16'({$random(seed)} % 5));
		end
		req_valid <= 1'b0;
		for (i = 0; i < 2; i++) begin
			{irq_a, irq_b} <= i ? 2'h1 : 2'h2;
			repeat (6) @(posedge clock);
			#1;
			check(inta_bus === i[0] && intb_bus === !i[0]);
			check(inta_n_out === 1'b0 && intb_n_out === 1'b0);
		end
		@(posedge clock);
		{target_active, req_valid} <= 2'h3;
		repeat (2) @(posedge clock);
		#1;
		check(!cbe_oe && cmd_valid === 1'b1);
		@(posedge clock);
		{target_active, req_valid} <= 2'h0;
		{req_valid, irq_a, irq_b} <= 3'h7;
		global_reset_n <= 1'b0;
		repeat (5) @(posedge clock);
		#1;
		check(!cbe_oe && !cmd_valid && inta_bus && intb_bus);
		test_done();
	end
endmodule
